// *** src/psc_consts.svh ***
// Offsets, field positions, reset values and timing counts of the strap loader.
// Assumes inclusion by bare name from files under src/.
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

// Register byte offsets on the bus
`define PSC_OFF_CTRL 8'h00
`define PSC_OFF_ADV 8'h04
`define PSC_OFF_CFG 8'h08
`define PSC_OFF_STAT 8'h0C

// Control word bit positions
`define PSC_CTRL_SPEED 13
`define PSC_CTRL_AN_EN 12
`define PSC_CTRL_RESTART 9
`define PSC_CTRL_DUPLEX 8

// Advertisement field, bits 5 to 8
`define PSC_ADV_LSB 5
`define PSC_ADV_MSB 8

// Configuration word bit positions
`define PSC_CFG_LINK_TEST 8
`define PSC_CFG_SCRAMBLE 3
`define PSC_CFG_FX 2

// Status word bit positions
`define PSC_STAT_ADDR_LSB 0
`define PSC_STAT_PINS_LSB 4

// Reset values before the straps are latched
`define PSC_RST_BIT 1'h0
`define PSC_RST_ADV 4'hF

// Cycles from a request to its acknowledge
`define PSC_ACK_CYCLES 1

`endif

// *** src/psc_pkg.sv ***
// Types carried between the strap loader modules.
// Assumes nothing beyond a SystemVerilog compiler.
package psc_pkg;

    // One decoded multi-level strap: address bit and function bit
    typedef struct packed {
        logic addr;
        logic func;
    } psc_strap_t;

    // Control bits held by the loader
    typedef struct packed {
        logic speed_100;
        logic an_enable;
        logic an_restart;
        logic full_duplex;
    } psc_ctrl_t;

    // Advertisement bits, most significant first
    typedef struct packed {
        logic adv_100_fd;
        logic adv_100;
        logic adv_10_fd;
        logic adv_10;
    } psc_adv_t;

    // Configuration bits held by the loader
    typedef struct packed {
        logic link_test_dis;
        logic scram_bypass;
        logic fx_mode;
    } psc_cfg_t;

endpackage

// *** src/psc_cfg_field.sv ***
// One register field that hardware can load and software can write.
// Assumes a synchronous active-high reset and a single clock.
`timescale 1ns/100ps
module psc_cfg_field #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    input wire logic wr_i,
    input wire logic [W-1:0] wr_val_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] q_ff; // Held field value
    logic [W-1:0] nxt_q; // Next field value

    // Hardware load beats a write so that pin control stays in charge
    assign nxt_q = load_i ? load_val_i : (wr_i ? wr_val_i : q_ff);

    // Field storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_ff <= RST_VAL;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q_o = q_ff;

endmodule

// *** src/psc_rise_det.sv ***
// Rising-edge detector for a synchronous input pin.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/100ps
module psc_rise_det (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic rise_o
);

    logic prev_ff; // Pin level one cycle ago

    // Reset to high so a pin already high at release is no edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_ff <= 1'h1;
        end else begin
            prev_ff <= pin_i;
        end
    end

    assign rise_o = pin_i & ~prev_ff;

endmodule

// *** src/psc_strap_loader.sv ***
// Strap and control pin loader for a 10/100 transceiver, with a Wishbone slave.
// Assumes pins synchronous to clk_i and straps already decoded to two bits.
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
`include "psc_consts.svh"
module psc_strap_loader (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Decoded straps and control pins
    input wire psc_pkg::psc_strap_t autoneg_strap_i,
    input wire psc_pkg::psc_strap_t scrambler_strap_i,
    input wire psc_pkg::psc_strap_t speed_medium_strap_i,
    input wire logic duplex_pin_i,
    input wire logic speed_restart_pin_i,
    input wire logic link_test_pin_i,
    input wire logic management_disable_i,
    // Results toward the transceiver core
    output psc_pkg::psc_ctrl_t ctrl_o,
    output psc_pkg::psc_adv_t adv_o,
    output psc_pkg::psc_cfg_t cfg_o,
    output logic [2:0] mgmt_addr_o,
    output logic an_restart_o
);

    // Single-cycle classic slave: it answers one cycle after a request
    // Bus handshake state
    logic ack_ff; // Acknowledge, one cycle per request
    logic [31:0] dat_ff; // Read data captured with acknowledge
    logic [31:0] nxt_dat;

    // Loader state
    logic load_pend_ff; // High for the first cycle after reset release
    logic [2:0] addr_ff; // Latched management address bits 4, 3, 0
    logic restart_ff; // Restart control bit
    logic nxt_restart;
    logic pulse_ff; // One-cycle restart request to the core

    // Each writable field except the restart bit lives in a field cell so that load and write
    // priority is the same for every bit
    // Field outputs of the storage cells
    logic speed_q;
    logic an_en_q;
    logic duplex_q;
    logic [3:0] adv_q;
    logic link_test_q;
    logic scram_q;
    logic fx_q;

    // Register map, byte addresses on the bus:
    //   control word: speed, negotiation enable, restart and duplex bits
    //   advertisement word: four capability bits in bits 8 to 5
    //   configuration word: link-test disable, scrambler bypass, fiber mode
    //   status word: latched address bits and live pin levels, read only
    // Only full-address matches decode, so aliases read as zero.
    // Bus decode
    wire req = wb_cyc_i & wb_stb_i;
    wire start = req & ~ack_ff;
    wire commit = req & ack_ff & wb_we_i; // Write lands at the acknowledged edge
    wire hit_ctrl = (wb_adr_i == `PSC_OFF_CTRL);
    wire hit_adv = (wb_adr_i == `PSC_OFF_ADV);
    wire hit_cfg = (wb_adr_i == `PSC_OFF_CFG);
    wire hit_stat = (wb_adr_i == `PSC_OFF_STAT);
    wire [31:0] sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Unused bits of every word read as zero; a write to them is dropped
    // because no storage stands behind them.
    // Current register images
    wire [31:0] ctrl_word = (32'h1 << `PSC_CTRL_SPEED) * {31'h0, speed_q}
                          | (32'h1 << `PSC_CTRL_AN_EN) * {31'h0, an_en_q}
                          | (32'h1 << `PSC_CTRL_RESTART) * {31'h0, restart_ff}
                          | (32'h1 << `PSC_CTRL_DUPLEX) * {31'h0, duplex_q};
    wire [31:0] adv_word = {23'h0, adv_q, 5'h0};
    wire [31:0] cfg_word = (32'h1 << `PSC_CFG_LINK_TEST) * {31'h0, link_test_q}
                         | (32'h1 << `PSC_CFG_SCRAMBLE) * {31'h0, scram_q}
                         | (32'h1 << `PSC_CFG_FX) * {31'h0, fx_q};
    wire [31:0] stat_word = {24'h0, management_disable_i, link_test_pin_i,
                             speed_restart_pin_i, duplex_pin_i, 1'h0, addr_ff};

    // Byte-lane merge: unselected lanes keep their stored bits
    wire [31:0] wr_ctrl = (wb_dat_i & sel_mask) | (ctrl_word & ~sel_mask);
    wire [31:0] wr_adv = (wb_dat_i & sel_mask) | (adv_word & ~sel_mask);
    wire [31:0] wr_cfg = (wb_dat_i & sel_mask) | (cfg_word & ~sel_mask);
    wire wr_ctrl_en = commit & hit_ctrl;
    wire wr_adv_en = commit & hit_adv;
    wire wr_cfg_en = commit & hit_cfg;

    // Read mux; unmapped addresses read zero and still acknowledge
    // Acknowledging them keeps a stray access from hanging the master;
    // the cost is that a bad address goes unnoticed.
    assign nxt_dat = hit_ctrl ? ctrl_word :
                     hit_adv ? adv_word :
                     hit_cfg ? cfg_word :
                     hit_stat ? stat_word : 32'h0;

    // Strap enable picks meanings
    // On the preset cycle the stored enable is not yet valid, so use the strap
    // After that cycle software may change the enable and with it the pin meanings
    wire an_sel = load_pend_ff ? autoneg_strap_i.func : an_en_q;

    // Forced while disabled
    // One load strobe serves both cases: one cycle long after release,
    // every cycle while management is disabled. A write then loses to the
    // pins, which is what keeps the pins in charge.
    wire drive = load_pend_ff | management_disable_i;
    wire drive_off = drive & ~an_sel; // Pins carry forced-mode meaning
    wire drive_on = drive & an_sel; // Pins carry advertisement meaning

    // Speed advertisement combination
    // Strap high means 100-capable, link-test pin picks the speed subset
    // Link-test low with strap low offers everything and ignores duplex.
    // Otherwise the duplex pin decides each full-duplex bit that is offered.
    logic [3:0] adv_pins; // {100 FD, 100, 10 FD, 10}
    always_comb begin
        unique case ({speed_medium_strap_i.func, link_test_pin_i})
            2'b00: adv_pins = 4'hF;
            2'b01: adv_pins = {2'h0, duplex_pin_i, 1'h1};
            2'b10: adv_pins = {duplex_pin_i, 1'h1, 2'h0};
            2'b11: adv_pins = {duplex_pin_i, 1'h1, duplex_pin_i, 1'h1};
        endcase
    end

    // Handshake and read data; ack drops the cycle after it rose
    // Read data is captured at the request edge so it stands with ack and
    // keeps its value afterwards; a request still high while ack is up is
    // not taken again, which forces an idle cycle between transfers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'h0;
            dat_ff <= 32'h0;
        end else begin
            ack_ff <= start;
            dat_ff <= start ? nxt_dat : dat_ff;
        end
    end

    // Address half of straps
    // Straps are expected to hold still while reset is high, so one sample
    // on the first cycle after release is enough.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_pend_ff <= 1'h1;
            addr_ff <= 3'h0;
        end else begin
            load_pend_ff <= 1'h0;
            if (load_pend_ff) begin
                addr_ff <= {speed_medium_strap_i.addr, scrambler_strap_i.addr,
                            autoneg_strap_i.addr};
            end
        end
    end

    // Duplex bit from pin
    // Loads in forced meaning only; with negotiation on software owns it
    psc_cfg_field #(.W(1), .RST_VAL(`PSC_RST_BIT)) u_duplex (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(drive_off),
        .load_val_i(duplex_pin_i),
        .wr_i(wr_ctrl_en),
        .wr_val_i(wr_ctrl[`PSC_CTRL_DUPLEX]),
        .q_o(duplex_q)
    );

    // Speed bit from pin
    // A fiber board keeps this pin high, so fiber loads 100 at preset and while management is disabled
    psc_cfg_field #(.W(1), .RST_VAL(`PSC_RST_BIT)) u_speed (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(drive_off),
        .load_val_i(speed_restart_pin_i),
        .wr_i(wr_ctrl_en),
        .wr_val_i(wr_ctrl[`PSC_CTRL_SPEED]),
        .q_o(speed_q)
    );

    // Enable preset from strap
    // Never forced by pins; software may turn negotiation on or off later
    psc_cfg_field #(.W(1), .RST_VAL(`PSC_RST_BIT)) u_an_en (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load_pend_ff),
        .load_val_i(autoneg_strap_i.func),
        .wr_i(wr_ctrl_en),
        .wr_val_i(wr_ctrl[`PSC_CTRL_AN_EN]),
        .q_o(an_en_q)
    );

    // Advertisement bits from strap and pins
    // Resets to all capabilities so an unstrapped part offers everything
    psc_cfg_field #(.W(4), .RST_VAL(`PSC_RST_ADV)) u_adv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(drive_on),
        .load_val_i(adv_pins),
        .wr_i(wr_adv_en),
        .wr_val_i(wr_adv[`PSC_ADV_MSB:`PSC_ADV_LSB]),
        .q_o(adv_q)
    );

    // Link-test bit from pin
    // High disables the 10 Mbps link test
    psc_cfg_field #(.W(1), .RST_VAL(`PSC_RST_BIT)) u_link_test (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(drive_off),
        .load_val_i(link_test_pin_i),
        .wr_i(wr_cfg_en),
        .wr_val_i(wr_cfg[`PSC_CFG_LINK_TEST]),
        .q_o(link_test_q)
    );

    // Scrambler bypass preset
    // Preset only; software owns the bypass after release
    psc_cfg_field #(.W(1), .RST_VAL(`PSC_RST_BIT)) u_scram (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load_pend_ff),
        .load_val_i(scrambler_strap_i.func),
        .wr_i(wr_cfg_en),
        .wr_val_i(wr_cfg[`PSC_CFG_SCRAMBLE]),
        .q_o(scram_q)
    );

    // TX or FX preset
    // Only meaningful with autonegotiation off; FX also needs the restart pin high
    psc_cfg_field #(.W(1), .RST_VAL(`PSC_RST_BIT)) u_fx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load_pend_ff & ~an_sel),
        .load_val_i(speed_medium_strap_i.func),
        .wr_i(wr_cfg_en),
        .wr_val_i(wr_cfg[`PSC_CFG_FX]),
        .q_o(fx_q)
    );

    // Edge of the speed/restart pin
    // The detector runs even with negotiation off, so turning it on later
    // does not see a stale edge.
    logic restart_rise;
    psc_rise_det u_rise (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(speed_restart_pin_i),
        .rise_o(restart_rise)
    );

    // Rising edge restarts negotiation
    // The edge sets the bit even in the cycle software clears it
    // Edges are ignored on the preset cycle: the enable is not stored yet.
    wire restart_set = restart_rise & an_en_q & ~load_pend_ff;
    assign nxt_restart = restart_set ? 1'h1 :
                         (wr_ctrl_en ? wr_ctrl[`PSC_CTRL_RESTART] : restart_ff);

    // Restart bit and the request pulse; a software write of one also restarts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            restart_ff <= 1'h0;
            pulse_ff <= 1'h0;
        end else begin
            restart_ff <= nxt_restart;
            pulse_ff <= restart_set | (wr_ctrl_en & wr_ctrl[`PSC_CTRL_RESTART]);
        end
    end

    // Outputs, all straight from flops
    // Every output below is a plain rename of a register, never logic.
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign ctrl_o = '{speed_100: speed_q, an_enable: an_en_q,
                      an_restart: restart_ff, full_duplex: duplex_q};
    assign adv_o = adv_q;
    assign cfg_o = '{link_test_dis: link_test_q, scram_bypass: scram_q,
                     fx_mode: fx_q};
    assign mgmt_addr_o = addr_ff;
    assign an_restart_o = pulse_ff;

endmodule

// *** verif/psc_properties.sv ***
// Port-level checks on the strap loader.
// Assumes a bind to psc_strap_loader and straps that change only in reset.
`timescale 1ns/100ps
module psc_props_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire psc_pkg::psc_strap_t autoneg_strap_i,
    input wire psc_pkg::psc_strap_t scrambler_strap_i,
    input wire psc_pkg::psc_strap_t speed_medium_strap_i,
    input wire logic duplex_pin_i,
    input wire logic speed_restart_pin_i,
    input wire logic link_test_pin_i,
    input wire logic management_disable_i,
    input wire psc_pkg::psc_ctrl_t ctrl_o,
    input wire psc_pkg::psc_adv_t adv_o,
    input wire psc_pkg::psc_cfg_t cfg_o,
    input wire logic [2:0] mgmt_addr_o,
    input wire logic an_restart_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Forced mode needs the stored enable, so the preset edge is skipped
    wire logic frc = management_disable_i && !ctrl_o.an_enable;
    // Advertisement table, most significant bit first
    function automatic logic [3:0] adv_of(input logic f, input logic l, input logic d);
        return (!f && !l) ? 4'hF : {f & d, f, l & d, l};
    endfunction
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    AST_ACK_ONCE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    AST_FRC_DUP: assert property (frc && !$past(rst_i) |=>
        ctrl_o.full_duplex == $past(duplex_pin_i)) else $error("duplex not forced");
    AST_FRC_SPD: assert property (frc && !$past(rst_i) |=>
        ctrl_o.speed_100 == $past(speed_restart_pin_i)) else $error("speed not forced");
    AST_FRC_LT: assert property (frc && !$past(rst_i) |=>
        cfg_o.link_test_dis == $past(link_test_pin_i)) else $error("ltest not forced");
    AST_RESTART: assert property (ctrl_o.an_enable && !$past(rst_i) &&
        $rose(speed_restart_pin_i) |=> an_restart_o && ctrl_o.an_restart)
        else $error("restart missed");
    AST_ADV: assert property (management_disable_i && ctrl_o.an_enable &&
        !$past(rst_i) |=> adv_o == adv_of(speed_medium_strap_i.func,
        $past(link_test_pin_i), $past(duplex_pin_i))) else $error("adv not forced");
    AST_ADDR: assert property (!$past(rst_i) |-> mgmt_addr_o ==
        {speed_medium_strap_i.addr, scrambler_strap_i.addr, autoneg_strap_i.addr})
        else $error("address bits wrong");
    AST_PRESET: assert property ($fell(rst_i) |=>
        ctrl_o.an_enable == autoneg_strap_i.func && cfg_o.scram_bypass ==
        scrambler_strap_i.func && cfg_o.fx_mode == (speed_medium_strap_i.func &&
        !autoneg_strap_i.func)) else $error("preset wrong");
endmodule

// *** verif/psc_pin_model.sv ***
// Board straps and control logic in front of the strap loader.
// Assumes the bench sets the wanted levels; straps arrive decoded.
`timescale 1ns/100ps
module psc_pin_model (
    input wire psc_pkg::psc_strap_t an_i,
    input wire psc_pkg::psc_strap_t scr_i,
    input wire psc_pkg::psc_strap_t sm_i,
    input wire logic spd_i,
    output psc_pkg::psc_strap_t an_o,
    output psc_pkg::psc_strap_t scr_o,
    output psc_pkg::psc_strap_t sm_o,
    output logic spd_o
);
    assign an_o = an_i;
    assign scr_o = scr_i;
    assign sm_o = sm_i;
    assign spd_o = spd_i | (sm_i.func & !an_i.func);
endmodule

// *** verif/tb_phy_strap_config.sv ***
// Bench for the strap loader: boots every mix of strap functions, then override,
// forcing and restart. Assumes the pin model and the bound checker.
`timescale 1ns/100ps
module tb_phy_strap_config;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, rstp;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic dup = 1'b0, spd = 1'b0, lt = 1'b0, md = 1'b0, spd_w;
    psc_pkg::psc_strap_t an = '0, scr = '0, sm = '0, an_w, scr_w, sm_w;
    psc_pkg::psc_ctrl_t ctrl;
    psc_pkg::psc_adv_t adv;
    psc_pkg::psc_cfg_t cfg;
    logic [2:0] maddr;
    int failures = 0, total_checks = 0, seed = 32'h299B0ED3;
    always #2.5 clk_i = ~clk_i;
    psc_pin_model u_pins (.an_i(an), .scr_i(scr), .sm_i(sm), .spd_i(spd),
        .an_o(an_w), .scr_o(scr_w), .sm_o(sm_w), .spd_o(spd_w));
    psc_strap_loader DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .autoneg_strap_i(an_w), .scrambler_strap_i(scr_w),
        .speed_medium_strap_i(sm_w), .duplex_pin_i(dup), .speed_restart_pin_i(spd_w),
        .link_test_pin_i(lt), .management_disable_i(md), .ctrl_o(ctrl), .adv_o(adv),
        .cfg_o(cfg), .mgmt_addr_o(maddr), .an_restart_o(rstp));
    function automatic logic [3:0] adv_of(input logic f, input logic l, input logic d);
        return (!f && !l) ? 4'hF : {f & d, f, l & d, l};
    endfunction
    task automatic wrap_up;
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            n++;
            if (n > 20) begin
                failures++;
                wrap_up();
            end
            @(posedge clk_i);
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // Straps change only while reset is held
    task automatic boot(input logic [2:0] f, input logic [2:0] a);
        rst_i <= 1'b1;
        an <= {a[0], f[0]};
        scr <= {a[1], f[1]};
        sm <= {a[2], f[2]};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic jiggle;
        repeat (60) begin
            @(posedge clk_i);
            {dup, spd, lt} <= 3'($random(seed));
        end
        @(posedge clk_i);
    endtask
    initial begin
        string nm [4];
        logic [31:0] ex [4];
        logic sp;
        nm = '{"ctrl", "adv", "cfg", "stat"};
        for (int i = 0; i < 16; i++) begin
            {dup, spd} <= 2'($random(seed));
            lt <= i[3];
            boot(3'(i), 3'($random(seed)));
            sp = spd | (sm.func & !an.func);
            ex[0] = an.func ? 32'h1000 : {18'h0, sp, 4'h0, dup, 8'h00};
            ex[1] = {23'h0, an.func ? adv_of(sm.func, lt, dup) : 4'hF, 5'h00};
            ex[2] = {23'h0, lt & !an.func, 4'h0, scr.func, sm.func & !an.func, 2'h0};
            ex[3] = {24'h0, md, lt, sp, dup, 1'b0, sm.addr, scr.addr, an.addr};
            for (int k = 0; k < 4; k++) begin
                wb(1'b0, 8'(k * 4), 32'h0);
                chk(nm[k], ex[k], rdat);
            end
            chk("maddr", {29'h0, sm.addr, scr.addr, an.addr}, {29'h0, maddr});
        end
        boot(3'b000, 3'b101);
        ex[0] = {18'h0, !spd, 4'h0, !dup, 8'h00};
        wb(1'b1, 8'h00, ex[0]);
        sel <= 4'h1;
        wb(1'b1, 8'h00, 32'h0);
        sel <= 4'hF;
        wb(1'b1, 8'h0C, 32'hFFFFFFFF);
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl", ex[0], rdat);
        wb(1'b0, 8'h0C, 32'h0);
        chk("stat", {25'h0, lt, spd, dup, 4'h5}, rdat);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rdat);
        md <= 1'b1;
        jiggle();
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl", {18'h0, spd, 4'h0, dup, 8'h00}, rdat);
        wb(1'b0, 8'h08, 32'h0);
        chk("cfg", {23'h0, lt, 8'h00}, rdat);
        md <= 1'b0;
        spd <= 1'b0;
        boot(3'b101, 3'b010);
        spd <= 1'b1;
        @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl", 32'h1200, rdat);
        wb(1'b1, 8'h00, 32'h1000);
        wb(1'b0, 8'h00, 32'h0);
        chk("ctrl", 32'h1000, rdat);
        md <= 1'b1;
        jiggle();
        wb(1'b0, 8'h04, 32'h0);
        chk("adv", {23'h0, adv_of(1'b1, lt, dup), 5'h00}, rdat);
        wrap_up();
    end
endmodule
bind psc_strap_loader psc_props_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .autoneg_strap_i(autoneg_strap_i), .scrambler_strap_i(scrambler_strap_i),
    .speed_medium_strap_i(speed_medium_strap_i), .duplex_pin_i(duplex_pin_i),
    .speed_restart_pin_i(speed_restart_pin_i), .link_test_pin_i(link_test_pin_i),
    .management_disable_i(management_disable_i), .ctrl_o(ctrl_o), .adv_o(adv_o),
    .cfg_o(cfg_o), .mgmt_addr_o(mgmt_addr_o), .an_restart_o(an_restart_o));
